// >>> rcb_eval.sv
// rcb_eval: combinational condition evaluation for mask and range tests
// assumes operands are stable during the evaluating cycle
`default_nettype none
module rcb_eval
   import rcb_pkg::*;
(
   input  wire logic [3:0]        op,
   input  wire logic [DATA_W-1:0] reg_val,
   input  wire logic [DATA_W-1:0] p1,
   input  wire logic [DATA_W-1:0] p2,
   output logic                   valid_op,
   output logic                   cond
);
   logic [DATA_W-1:0] hit;
   logic              all_t;
   logic              any_t;
   logic              lo_gt, lo_ge, hi_lt, hi_le;

   always_comb begin
      // tested bit is true when it matches the state level
      hit    = ~(reg_val ^ p1) | ~p2;
      all_t  = &hit;
      any_t  = |(~(reg_val ^ p1) & p2);
      lo_gt  = $signed(reg_val) >  $signed(p1);
      lo_ge  = $signed(reg_val) >= $signed(p1);
      hi_lt  = $signed(reg_val) <  $signed(p2);
      hi_le  = $signed(reg_val) <= $signed(p2);
      valid_op = 1'b1;
      cond     = 1'b0;
      unique case (op)
         OP_AND:    cond = all_t;
         OP_OR:     cond = any_t;
         OP_NAND:   cond = ~all_t;
         OP_NOR:    cond = ~any_t;
         OP_IN_XX:  cond = lo_gt & hi_lt;
         OP_IN_IX:  cond = lo_ge & hi_lt;
         OP_IN_XI:  cond = lo_gt & hi_le;
         OP_IN_II:  cond = lo_ge & hi_le;
         OP_OUT_II: cond = ~lo_gt | ~hi_lt;
         OP_OUT_XI: cond = ~lo_ge | ~hi_lt;
         OP_OUT_IX: cond = ~lo_gt | ~hi_le;
         OP_OUT_XX: cond = ~lo_ge | ~hi_le;
         default:   valid_op = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// >>> rcb_pkg.sv
// rcb_pkg: constants for the register compare branch unit
// assumes a sequencer that presents decoded command words in one cycle
`default_nettype none
package rcb_pkg;
   localparam logic [7:0]  CMD_REG_MASK   = 8'h59;
   localparam logic [7:0]  CMD_REG_CMP    = 8'h89;
   localparam logic [7:0]  TYPE_JUMP      = 8'h00;
   localparam logic [7:0]  CMP_GE         = 8'h01;
   localparam logic [7:0]  CMP_GT         = 8'h04;
   localparam logic [3:0]  OP_AND         = 4'h0;
   localparam logic [3:0]  OP_OR          = 4'h1;
   localparam logic [3:0]  OP_NAND        = 4'h2;
   localparam logic [3:0]  OP_NOR         = 4'h3;
   localparam logic [3:0]  OP_IN_XX       = 4'h4;
   localparam logic [3:0]  OP_IN_IX       = 4'h5;
   localparam logic [3:0]  OP_IN_XI       = 4'h6;
   localparam logic [3:0]  OP_IN_II       = 4'h7;
   localparam logic [3:0]  OP_OUT_II      = 4'h8;
   localparam logic [3:0]  OP_OUT_XI      = 4'h9;
   localparam logic [3:0]  OP_OUT_IX      = 4'hA;
   localparam logic [3:0]  OP_OUT_XX      = 4'hB;
   localparam int          DATA_W         = 32;
   localparam int          PC_W           = 16;
   // type byte starts at this bit; the operation field is the low nibble
   localparam int          TYPE_LSB       = 8;
   localparam int          OP_W           = 4;
   localparam logic [15:0] PC_RESET       = 16'h0000;
endpackage
`default_nettype wire

// >>> rcb_regs.sv
// rcb_regs: register file behind the unit, read without delay
// assumes the bench writes a register before naming it
`default_nettype none
module rcb_regs (
   input  wire logic        clk,
   input  wire logic        we,
   input  wire logic [7:0]  wi,
   input  wire logic [31:0] wv,
   input  wire logic [7:0]  ri,
   output logic [31:0]      rv
);
   timeunit 1ns / 1ps;
   logic [31:0] mem [256];
   always_ff @(posedge clk) if (we) mem[wi] <= wv;
   assign rv = mem[ri];
endmodule
`default_nettype wire

// >>> rcb_top.sv
// rcb_top: branch decision and program counter update for compare jumps
// assumes the sequencer holds a command one cycle with CMD_VALID and
// supplies the selected register contents on REG_DATA in that cycle
//
// Overview of operation
// - mask command compares a register with two signed 32-bit constants, jumps if true
// - mask jump and mask call share code 0x59; high type byte zero means jump
// - low byte of type/operation word picks the test against state and enable
// - bitwise tests look only at register bits set in enable
// - a tested bit is true when it equals the state bit; results combine
// - bitwise codes: 0 AND, 1 OR, 2 NAND, 3 NOR
// - codes 4 to 7 are inside-range tests with varying bound inclusion
// - codes 8 to 11 are outside-range tests with varying bound strictness
// - register compares share code 0x89; type high byte, register low byte
// - type 1 jumps when register is at or above the signed value
// - type 4 jumps when register is strictly above the signed value
// - NAND: no branch when all tested bits true, branch if any false
`default_nettype none
module rcb_top
   import rcb_pkg::*;
(
   input  wire logic              CLK_SYS,
   input  wire logic              RESET,
   input  wire logic              CMD_VALID,
   input  wire logic [7:0]        CMD_CODE,
   input  wire logic [15:0]       CMD_OPWORD,
   input  wire logic [7:0]        CMD_REGSEL,
   input  wire logic [DATA_W-1:0] CMD_P1,
   input  wire logic [DATA_W-1:0] CMD_P2,
   input  wire logic [PC_W-1:0]   CMD_TARGET,
   input  wire logic [PC_W-1:0]   CMD_NEXT_PC,
   input  wire logic [DATA_W-1:0] REG_DATA,
   output logic [7:0]             REG_SEL,
   output logic                   PC_LOAD,
   output logic [PC_W-1:0]        PC_VALUE,
   output logic                   TAKEN,
   output logic                   ACK,
   output logic                   UNHANDLED
);
   typedef struct packed {
      logic [7:0]      reg_sel;
      logic            pc_load;
      logic [PC_W-1:0] pc_value;
      logic            taken;
      logic            ack;
      logic            unhandled;
   } rcb_state_t;

   // class of the presented command as far as this unit is concerned
   typedef enum logic [1:0] {
      CLS_MASK_JUMP,
      CLS_CMP_JUMP,
      CLS_FOREIGN
   } rcb_class_t;

   rcb_state_t st_r;
   rcb_state_t st_nxt;
   rcb_class_t cls;
   logic       mask_valid_op;
   logic       mask_cond;
   logic       cond;

   // type byte of the type/operation word
   function automatic logic [7:0] type_byte(
      input logic [15:0] opword
   );
      return opword[TYPE_LSB +: 8];
   endfunction

   // low byte: operation for the mask command, register number for compares
   function automatic logic [7:0] low_byte(
      input logic [15:0] opword
   );
      return opword[TYPE_LSB-1:0];
   endfunction

   // the call variant shares the code; only type zero with a known operation jumps
   function automatic logic mask_jump(
      input logic [7:0]  code,
      input logic [15:0] opword,
      input logic        op_known
   );
      return (code == CMD_REG_MASK)
             && (type_byte(opword) == TYPE_JUMP)
             && (opword[TYPE_LSB-1:OP_W] == '0)
             && op_known;
   endfunction

   // equal, not-equal and the less-than compares are left to another unit
   function automatic logic cmp_jump(
      input logic [7:0]  code,
      input logic [15:0] opword
   );
      logic [7:0] ty;
      ty = type_byte(opword);
      return (code == CMD_REG_CMP) && ((ty == CMP_GE) || (ty == CMP_GT));
   endfunction

   // both compares are signed over the full data width
   function automatic logic cmp_cond(
      input logic [7:0]        ty,
      input logic [DATA_W-1:0] reg_val,
      input logic [DATA_W-1:0] value
   );
      logic at_or_above;
      logic above;
      at_or_above = $signed(reg_val) >= $signed(value);
      above       = $signed(reg_val) >  $signed(value);
      return (ty == CMP_GE) ? at_or_above : above;
   endfunction

   // compares carry the register in the low byte, the mask command in its own word
   function automatic logic [7:0] pick_reg(
      input logic [7:0]  code,
      input logic [15:0] opword,
      input logic [7:0]  regsel
   );
      return (code == CMD_REG_CMP) ? low_byte(opword) : regsel;
   endfunction

   rcb_eval u_eval (
      .op       (CMD_OPWORD[OP_W-1:0]),
      .reg_val  (REG_DATA),
      .p1       (CMD_P1),
      .p2       (CMD_P2),
      .valid_op (mask_valid_op),
      .cond     (mask_cond)
   );

   always_comb begin
      cls = CLS_FOREIGN;
      if (mask_jump(CMD_CODE, CMD_OPWORD, mask_valid_op))
         cls = CLS_MASK_JUMP;
      else if (cmp_jump(CMD_CODE, CMD_OPWORD))
         cls = CLS_CMP_JUMP;
      unique case (cls)
         CLS_MASK_JUMP: cond = mask_cond;
         CLS_CMP_JUMP:  cond = cmp_cond(type_byte(CMD_OPWORD), REG_DATA, CMD_P1);
         default:       cond = 1'b0;
      endcase
      st_nxt           = st_r;
      st_nxt.pc_load   = 1'b0;
      st_nxt.ack       = 1'b0;
      st_nxt.unhandled = 1'b0;
      st_nxt.taken     = 1'b0;
      if (CMD_VALID) begin
         // selection holds until the next command so the sequencer may read it late
         st_nxt.reg_sel = pick_reg(CMD_CODE, CMD_OPWORD, CMD_REGSEL);
         if (cls != CLS_FOREIGN) begin
            st_nxt.ack      = 1'b1;
            st_nxt.pc_load  = 1'b1;
            st_nxt.taken    = cond;
            // not taken falls through to the following command
            st_nxt.pc_value = cond ? CMD_TARGET : CMD_NEXT_PC;
         end else begin
            // calls and other compares belong to another unit
            st_nxt.unhandled = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st_r <= '{reg_sel: 8'h00, pc_load: 1'b0, pc_value: PC_RESET,
                   taken: 1'b0, ack: 1'b0, unhandled: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign REG_SEL   = st_r.reg_sel;
   assign PC_LOAD   = st_r.pc_load;
   assign PC_VALUE  = st_r.pc_value;
   assign TAKEN     = st_r.taken;
   assign ACK       = st_r.ack;
   assign UNHANDLED = st_r.unhandled;
endmodule
`default_nettype wire

// >>> rcb_top_properties.sv
// rcb_chk: port checks of the compare branch decisions
// assumes one clock domain and an async active-high reset
`default_nettype none
module rcb_chk
   import rcb_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic        CMD_VALID,
   input wire logic [7:0]  CMD_CODE,
   input wire logic [15:0] CMD_OPWORD,
   input wire logic [31:0] CMD_P1,
   input wire logic [31:0] CMD_P2,
   input wire logic [31:0] REG_DATA,
   input wire logic [15:0] CMD_TARGET,
   input wire logic [15:0] CMD_NEXT_PC,
   input wire logic [15:0] PC_VALUE,
   input wire logic [7:0]  REG_SEL,
   input wire logic        PC_LOAD,
   input wire logic        TAKEN,
   input wire logic        ACK,
   input wire logic        UNHANDLED
);
   timeunit 1ns / 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   wire signed [31:0] r = REG_DATA, a = CMD_P1, b = CMD_P2;
   wire [7:0] ty = CMD_OPWORD[15:8], op = CMD_OPWORD[7:0];
   wire mk = CMD_VALID && CMD_CODE == CMD_REG_MASK && ty == TYPE_JUMP;
   wire cp = CMD_VALID && CMD_CODE == CMD_REG_CMP;
   wire ge = r >= a, gt = r > a, inr = a <= r && r <= b, outs = r < a || r > b;
   // enable zero leaves nothing to fail, so the AND form is true
   wire all_ok = ((REG_DATA ~^ CMD_P1) & CMD_P2) == CMD_P2;
   wire hj = (mk && op <= 8'h0B) || (cp && (ty == CMP_GE || ty == CMP_GT));
   AST_PC: assert property (hj |=> PC_LOAD && ACK
      && PC_VALUE == (TAKEN ? $past(CMD_TARGET) : $past(CMD_NEXT_PC)))
      else $error("bad pc update");
   AST_SEL: assert property (cp |=> REG_SEL == $past(op))
      else $error("bad register select");
   AST_GE: assert property (cp && ty == CMP_GE |=> TAKEN == $past(ge))
      else $error("bad ge jump");
   AST_GT: assert property (cp && ty == CMP_GT |=> TAKEN == $past(gt))
      else $error("bad gt jump");
   AST_AND: assert property (mk && op == 8'h00 |=> TAKEN == $past(all_ok))
      else $error("bad and mask");
   AST_NAND: assert property (mk && op == 8'h02 |=> TAKEN != $past(all_ok))
      else $error("bad nand mask");
   AST_IN: assert property (mk && op == 8'h07 |=> TAKEN == $past(inr))
      else $error("bad inside range");
   AST_OUT: assert property (mk && op == 8'h0B |=> TAKEN == $past(outs))
      else $error("bad outside range");
   AST_CALL: assert property (CMD_VALID && CMD_CODE == CMD_REG_MASK && ty != TYPE_JUMP
      |=> UNHANDLED && !PC_LOAD) else $error("call not refused");
   AST_ACK: assert property (ACK |-> PC_LOAD && !UNHANDLED)
      else $error("ack without load");
endmodule
bind rcb_top rcb_chk rcb_chk_inst (.CLK_SYS, .RESET, .CMD_VALID, .CMD_CODE, .CMD_OPWORD,
   .CMD_P1, .CMD_P2, .REG_DATA, .CMD_TARGET, .CMD_NEXT_PC, .PC_VALUE, .REG_SEL,
   .PC_LOAD, .TAKEN, .ACK, .UNHANDLED);
`default_nettype wire

// >>> testbench.sv
// testbench: compare jumps through rcb_top, judged at the pc update
// assumes rcb_regs answers the register read in the command cycle
`default_nettype none
module testbench;
   timeunit 1ns / 1ps;
   import rcb_pkg::*;
   logic clk = 0, rst = 1, vld = 0, we = 0, ld, tk, ack, unh;
   logic [7:0] code = 0, rs = 8'h0A, wi = 0, rsel;
   logic [15:0] ow = 0, pv;
   logic [31:0] a = 0, b = 0, wv = 0, rv;
   int miscompares = 0, total_checks = 0;
   rcb_regs rcb_regs_inst (.clk, .we, .wi, .wv, .ri(code == CMD_REG_CMP ? ow[7:0] : rs), .rv);
   rcb_top rcb_top_inst (.CLK_SYS(clk), .RESET(rst), .CMD_VALID(vld), .CMD_CODE(code),
      .CMD_OPWORD(ow), .CMD_REGSEL(rs), .CMD_P1(a), .CMD_P2(b), .CMD_TARGET(16'h000A),
      .CMD_NEXT_PC(16'h0021), .REG_DATA(rv), .REG_SEL(rsel), .PC_LOAD(ld), .PC_VALUE(pv),
      .TAKEN(tk), .ACK(ack), .UNHANDLED(unh));
   task chk(input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task run(input logic [7:0] c, input logic [15:0] o, input logic [31:0] v, p, q,
            input logic t, u);
      @(posedge clk);
      we <= 1'h1;
      wi <= c == CMD_REG_CMP ? o[7:0] : rs;
      wv <= v;
      @(posedge clk);
      we <= 1'h0;
      {vld, code, ow, a, b} <= {1'h1, c, o, p, q};
      @(posedge clk);
      vld <= 1'h0;
      #1;
      chk(16'({tk, unh, ack, ld}), 16'({t, u, !u, !u}));
      chk(16'(rsel), 16'(c == CMD_REG_CMP ? o[7:0] : rs));
      if (!u) chk(pv, t ? 16'h000A : 16'h0021);
   endtask
   task t_cmp;
      run(CMD_REG_CMP, 16'h0120, 32'h0000_04B0, 32'h0000_04B0, '0, 1'h1, 1'h0);
      run(CMD_REG_CMP, 16'h0420, 32'h0000_04B0, 32'h0000_04B0, '0, 1'h0, 1'h0);
      run(CMD_REG_CMP, 16'h0405, 32'h0000_04B1, 32'h0000_04B0, '0, 1'h1, 1'h0);
      run(CMD_REG_CMP, 16'h0120, 32'hFFFF_FFFF, '0, '0, 1'h0, 1'h0);
   endtask
   task t_mask;
      for (int i = 0; i < 12; i++) begin
         run(CMD_REG_MASK, 16'(i), 32'h0000_00F0, 32'h0000_0030, 32'h0000_00F0,
             1'(12'h3C6 >> i), 1'h0);
         run(CMD_REG_MASK, 16'(i), 32'h0000_0005, 32'h0000_0000, 32'h0000_0005,
             1'(12'h3CC >> i), 1'h0);
         run(CMD_REG_MASK, 16'(i), 32'h0000_0010, 32'h0000_0010, 32'h0000_0020,
             1'(12'h5A3 >> i), 1'h0);
         run(CMD_REG_MASK, 16'(i), 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0005,
             1'(12'hF0C >> i), 1'h0);
         run(CMD_REG_MASK, 16'(i), 32'h0000_0018, 32'h0000_0010, 32'h0000_0020,
             1'(12'h0F3 >> i), 1'h0);
      end
   endtask
   task t_refuse;
      run(CMD_REG_MASK, 16'h0100, '0, '0, '0, 1'h0, 1'h1);
      run(CMD_REG_MASK, 16'h000C, '0, '0, '0, 1'h0, 1'h1);
      run(CMD_REG_CMP, 16'h0220, '0, '0, '0, 1'h0, 1'h1);
      run(8'h00, 16'h0000, '0, '0, '0, 1'h0, 1'h1);
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      t_cmp;
      t_mask;
      t_refuse;
      test_done;
   end
endmodule
`default_nettype wire
